/* rtl/hbss_pkg.sv */
package hbss_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [7:0] HBSS_REG_CTRL = 8'h00;
    localparam logic [7:0] HBSS_REG_INTERVAL = 8'h04;
    localparam logic [7:0] HBSS_REG_DELAY = 8'h08;
    localparam logic [7:0] HBSS_REG_RETRY = 8'h0c;
    localparam logic [7:0] HBSS_REG_STATUS = 8'h10;
    localparam logic [7:0] HBSS_REG_CMD = 8'h14;
    localparam logic [7:0] HBSS_REG_IDENT = 8'h18;

    // ctrl fields
    localparam int HBSS_CTRL_RT_EN = 0;
    localparam int HBSS_CTRL_CALLOUT_EN = 1;
    localparam int HBSS_CTRL_MIRROR_EN = 2;
    // cmd fields (write one to act)
    localparam int HBSS_CMD_POWER_ON = 0;
    localparam int HBSS_CMD_OS_START = 1;
    localparam int HBSS_CMD_CLR_CALL = 2;

    // reset values and range limits
    localparam logic [7:0] HBSS_INTERVAL_RST = 8'h05;
    localparam logic [7:0] HBSS_DELAY_RST = 8'h01;
    localparam logic [7:0] HBSS_RETRY_RST = 8'h03;
    localparam logic [7:0] HBSS_INTERVAL_MIN = 8'h02;
    localparam logic [7:0] HBSS_INTERVAL_MAX = 8'hff;
    localparam logic [7:0] HBSS_DELAY_MAX = 8'hff;

    // timing
    localparam int HBSS_CLK_HZ = 10000000;
    localparam int HBSS_MINUTE_S = 60;
    localparam longint HBSS_MINUTE_CYCLES =
        longint'(HBSS_CLK_HZ) * HBSS_MINUTE_S;
    localparam logic [7:0] HBSS_BOOT_TIMEOUT_MIN = 8'h07;
    localparam int HBSS_PWR_OFF_MIN_CYCLES = 16;

    // error codes
    localparam logic [7:0] HBSS_ERR_NONE = 8'h00;
    localparam logic [7:0] HBSS_ERR_BOOT_RETRY = 8'h01;
    localparam logic [7:0] HBSS_ERR_BOOT_SURV = 8'h02;
    localparam logic [7:0] HBSS_ERR_OS_SURV = 8'h03;

    // prompt characters
    localparam logic [7:0] HBSS_CHAR_ONE = 8'h31;
    localparam logic [7:0] HBSS_CHAR_TWO = 8'h32;

    typedef enum logic [4:0] {
        HBSS_STANDBY = 5'b00001,
        HBSS_BRINGUP = 5'b00010,
        HBSS_PWRCYC = 5'b00100,
        HBSS_DELAY = 5'b01000,
        HBSS_RUN = 5'b10000
    } hbss_state_t;
endpackage

/* rtl/hbss_supervisor.sv */
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - stay in standby until a power-on request arrives
// - at bring-up, two consecutive failed boots post error and call out
// - boot heartbeat watch always runs at power-on, no switch for it
// - no boot heartbeat for seven minutes cycles system power
// - beyond max retries: stop cycling, stay powered, log error, menus on
// - repeated boot failure with call-out: call request and panel code
// - on boot failure report carries last boot progress status
// - run-time watch only with driver present and run-time enable set
// - run-time timeout calls out at once, no reboot attempts
// - interval accepts 2 to 255 minutes, others rejected
// - delay accepts 0 to 255 minutes
// - interval and delay writes refused while run-time enable is clear
// - mirroring on sends output to both serial ports
// - mirroring cleared when ports go back to host firmware
// - prompt names the serial port carrying the session
// - interval is longest wait in minutes for a heartbeat
// - delay holds off timeouts from os start to first heartbeat
// - run-time failure keeps power on, standby, shows failure code
module hbss_supervisor
    import hbss_pkg::*;
#(
    parameter longint MINUTE_CYCLES = HBSS_MINUTE_CYCLES
)
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic heartbeat_i,
    input wire logic driver_present_i,
    input wire logic [15:0] boot_progress_i,
    input wire logic session_port2_i,
    input wire logic ports_to_host_i,
    input wire logic [7:0] con_data_i,
    input wire logic con_valid_i,
    output logic [7:0] port1_data_o,
    output logic port1_valid_o,
    output logic [7:0] port2_data_o,
    output logic port2_valid_o,
    output logic [7:0] prompt_char_o,
    output logic sys_power_o,
    output logic call_req_o,
    output logic menus_avail_o,
    output logic [7:0] panel_code_o,
    output logic [15:0] report_status_o
);
    localparam logic [31:0] IDENT_VALUE = 32'h0000a5c3; // arbitrary value
    hbss_state_t state;
    logic [31:0] tick_cnt;
    logic tick;
    logic [7:0] min_left;
    logic [7:0] pwr_cnt;
    logic rt_en;
    logic callout_en;
    logic mirror_en;
    logic [7:0] interval;
    logic [7:0] delay_min;
    logic [7:0] max_retry;
    logic [7:0] fail_cnt;
    logic [7:0] err_code;
    logic wr_ok_rej;
    logic power_cmd;
    logic os_start_cmd;
    logic clr_call_cmd;
    logic boot_timeout;
    logic rt_timeout;
    logic rt_active;
    logic tmr_restart;
    function automatic logic is_wr(input logic [7:0] off);
        is_wr = wr_i && (addr_i == off);
    endfunction

    assign power_cmd = is_wr(HBSS_REG_CMD) && wdata_i[HBSS_CMD_POWER_ON];
    assign os_start_cmd = is_wr(HBSS_REG_CMD) && wdata_i[HBSS_CMD_OS_START];
    assign clr_call_cmd = is_wr(HBSS_REG_CMD) && wdata_i[HBSS_CMD_CLR_CALL];
    assign rt_active = rt_en && driver_present_i;
    assign boot_timeout = (state == HBSS_BRINGUP) && tick
        && (min_left == 8'h01) && !heartbeat_i;
    // delay phase never times out, only the run phase does
    assign rt_timeout = (state == HBSS_RUN) && rt_active && tick
        && (min_left == 8'h01) && !heartbeat_i;
    assign tmr_restart = heartbeat_i || state == HBSS_STANDBY
        || state == HBSS_PWRCYC || (os_start_cmd && state == HBSS_BRINGUP);

    // minute time base; restarts at each beat or timer load except the delay-expiry load into run, whose first minute runs short
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end
        else if (tmr_restart || (tick_cnt == 32'(MINUTE_CYCLES - 1)))
        begin
            tick_cnt <= 32'h0;
            tick <= !tmr_restart;
        end
        else
        begin
            tick_cnt <= tick_cnt + 32'h1;
            tick <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rt_en <= 1'b1;
            callout_en <= 1'b0;
            mirror_en <= 1'b0;
            interval <= HBSS_INTERVAL_RST;
            delay_min <= HBSS_DELAY_RST;
            max_retry <= HBSS_RETRY_RST;
            wr_ok_rej <= 1'b0;
        end
        else
        begin
            if (is_wr(HBSS_REG_CTRL))
            begin
                rt_en <= wdata_i[HBSS_CTRL_RT_EN];
                callout_en <= wdata_i[HBSS_CTRL_CALLOUT_EN];
                mirror_en <= wdata_i[HBSS_CTRL_MIRROR_EN];
            end
            if (ports_to_host_i)
                mirror_en <= 1'b0;
            if (is_wr(HBSS_REG_INTERVAL))
            begin
                if (rt_en && wdata_i[7:0] >= HBSS_INTERVAL_MIN
                    && wdata_i[7:0] <= HBSS_INTERVAL_MAX
                    && wdata_i[31:8] == 24'h0)
                begin
                    interval <= wdata_i[7:0];
                    wr_ok_rej <= 1'b0;
                end
                else
                    wr_ok_rej <= 1'b1;
            end
            if (is_wr(HBSS_REG_DELAY))
            begin
                if (rt_en && wdata_i[31:8] == 24'h0)
                begin
                    delay_min <= wdata_i[7:0];
                    wr_ok_rej <= 1'b0;
                end
                else
                    wr_ok_rej <= 1'b1;
            end
            if (is_wr(HBSS_REG_RETRY))
                max_retry <= wdata_i[7:0];
        end
    end

    // phase machine
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state <= HBSS_STANDBY;
            min_left <= 8'h0;
            pwr_cnt <= 8'h0;
            fail_cnt <= 8'h0;
            sys_power_o <= 1'b0;
            menus_avail_o <= 1'b1;
        end
        else
        begin
            unique case (state)
                HBSS_STANDBY:
                begin
                    menus_avail_o <= 1'b1;
                    if (power_cmd)
                    begin
                        state <= HBSS_BRINGUP;
                        sys_power_o <= 1'b1;
                        menus_avail_o <= 1'b0;
                        fail_cnt <= 8'h0;
                        min_left <= HBSS_BOOT_TIMEOUT_MIN;
                    end
                end
                HBSS_BRINGUP:
                begin
                    if (heartbeat_i)
                        min_left <= HBSS_BOOT_TIMEOUT_MIN;
                    else if (tick)
                        min_left <= min_left - 8'h1;
                    if (os_start_cmd)
                    begin
                        state <= HBSS_DELAY;
                        fail_cnt <= 8'h0;
                        min_left <= delay_min;
                    end
                    else if (boot_timeout)
                    begin
                        if (fail_cnt >= max_retry)
                        begin
                            state <= HBSS_STANDBY;
                            menus_avail_o <= 1'b1;
                        end
                        else
                        begin
                            state <= HBSS_PWRCYC;
                            sys_power_o <= 1'b0;
                            pwr_cnt <= 8'(HBSS_PWR_OFF_MIN_CYCLES);
                            fail_cnt <= fail_cnt + 8'h1;
                        end
                    end
                end
                HBSS_PWRCYC:
                begin
                    pwr_cnt <= pwr_cnt - 8'h1;
                    if (pwr_cnt == 8'h1)
                    begin
                        state <= HBSS_BRINGUP;
                        sys_power_o <= 1'b1;
                        min_left <= HBSS_BOOT_TIMEOUT_MIN;
                    end
                end
                HBSS_DELAY:
                begin
                    if (heartbeat_i || min_left == 8'h0)
                    begin
                        state <= HBSS_RUN;
                        min_left <= interval;
                    end
                    else if (tick)
                        min_left <= min_left - 8'h1;
                end
                HBSS_RUN:
                begin
                    if (heartbeat_i)
                        min_left <= interval;
                    else if (rt_timeout)
                        state <= HBSS_STANDBY;
                    else if (tick && rt_active)
                        min_left <= min_left - 8'h1;
                end
                default:
                    state <= HBSS_STANDBY;
            endcase
        end
    end

    // error code, call request and report
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            err_code <= HBSS_ERR_NONE;
            call_req_o <= 1'b0;
            report_status_o <= 16'h0;
        end
        else
        begin
            if (clr_call_cmd)
                call_req_o <= 1'b0;
            if (state == HBSS_STANDBY && power_cmd)
                err_code <= HBSS_ERR_NONE;
            if (boot_timeout)
            begin
                report_status_o <= boot_progress_i;
                if (fail_cnt >= max_retry)
                begin
                    err_code <= HBSS_ERR_BOOT_SURV;
                    call_req_o <= callout_en || call_req_o && !clr_call_cmd;
                end
                else if (fail_cnt >= 8'h1)
                begin
                    err_code <= HBSS_ERR_BOOT_RETRY;
                    call_req_o <= callout_en || call_req_o && !clr_call_cmd;
                end
            end
            if (rt_timeout)
            begin
                err_code <= HBSS_ERR_OS_SURV;
                call_req_o <= callout_en
                    || call_req_o && !clr_call_cmd;
            end
        end
    end

    // console paths
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            port1_data_o <= 8'h0;
            port1_valid_o <= 1'b0;
            port2_data_o <= 8'h0;
            port2_valid_o <= 1'b0;
            prompt_char_o <= HBSS_CHAR_ONE;
            panel_code_o <= HBSS_ERR_NONE;
        end
        else
        begin
            port1_data_o <= con_data_i;
            port2_data_o <= con_data_i;
            port1_valid_o <= con_valid_i
                && (mirror_en || !session_port2_i);
            port2_valid_o <= con_valid_i
                && (mirror_en || session_port2_i);
            prompt_char_o <= session_port2_i ? HBSS_CHAR_TWO
                : HBSS_CHAR_ONE;
            panel_code_o <= err_code;
        end
    end

    // register reads
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rdata_o <= 32'h0;
        else if (rd_i)
        begin
            unique case (addr_i)
                HBSS_REG_CTRL:
                    rdata_o <= {29'h0, mirror_en, callout_en, rt_en};
                HBSS_REG_INTERVAL: rdata_o <= {24'h0, interval};
                HBSS_REG_DELAY: rdata_o <= {24'h0, delay_min};
                HBSS_REG_RETRY: rdata_o <= {24'h0, max_retry};
                HBSS_REG_STATUS:
                    rdata_o <= {wr_ok_rej, 6'h0, rt_active, fail_cnt,
                        err_code, 3'h0, state};
                HBSS_REG_IDENT: rdata_o <= IDENT_VALUE;
                default: rdata_o <= 32'h0;
            endcase
        end
        else
            rdata_o <= 32'h0;
    end
endmodule

/* sim/hbss_assertions.sv */
`timescale 1ns/1ps
module hbss_checker
    import hbss_pkg::*;
#(
    parameter longint MINUTE_CYCLES = HBSS_MINUTE_CYCLES
)
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic heartbeat_i,
    input wire logic session_port2_i,
    input wire logic [7:0] con_data_i,
    input wire logic con_valid_i,
    input wire logic [7:0] port1_data_o,
    input wire logic port1_valid_o,
    input wire logic port2_valid_o,
    input wire logic [7:0] prompt_char_o,
    input wire logic sys_power_o,
    input wire logic call_req_o,
    input wire logic menus_avail_o,
    input wire logic [7:0] panel_code_o
);
    localparam logic [31:0] BOOT_CYC =
        32'(HBSS_BOOT_TIMEOUT_MIN * MINUTE_CYCLES);
    logic cmd_wr;
    logic [31:0] quiet;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    assign cmd_wr = wr_i && addr_i == HBSS_REG_CMD;
    // powered cycles since power-on or a beat; slack covers edge offsets
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            quiet <= 32'h0;
        else if (heartbeat_i || !sys_power_o
            || cmd_wr && wdata_i[HBSS_CMD_POWER_ON])
            quiet <= 32'h0;
        else
            quiet <= quiet + 32'h1;
    end
    sequence s_off_hold;
        !sys_power_o [*8] ##1 !sys_power_o [*7];
    endsequence
    a_power_cause: assert property (
        $rose(sys_power_o) |-> $past(cmd_wr && wdata_i[HBSS_CMD_POWER_ON])
        || !$past(sys_power_o, 14)) else $error("power rose uncommanded");
    a_power_cycle: assert property (
        $fell(sys_power_o) |-> s_off_hold ##[1:3] sys_power_o)
        else $error("power cycle hold wrong");
    a_boot_timeout: assert property (
        $fell(sys_power_o) |-> quiet + 32'h3 >= BOOT_CYC
        && quiet <= BOOT_CYC + 32'h3) else $error("boot timeout length");
    a_port1_copy: assert property (
        port1_valid_o |-> $past(con_valid_i)
        && port1_data_o == $past(con_data_i)) else $error("port1 copy");
    a_port2_cause: assert property (
        port2_valid_o |-> $past(con_valid_i)) else $error("port2 spurious");
    a_prompt_port: assert property (
        prompt_char_o == ($past(session_port2_i) ? HBSS_CHAR_TWO
        : HBSS_CHAR_ONE)) else $error("prompt wrong");
    a_rdata_idle: assert property (
        !$past(rd_i) |-> rdata_o == 32'h0) else $error("rdata not idle");
    a_call_sticky: assert property (
        $fell(call_req_o) |-> $past(cmd_wr && wdata_i[HBSS_CMD_CLR_CALL]))
        else $error("call dropped");
    a_call_code: assert property (
        $rose(call_req_o) |-> ##[0:2] panel_code_o != HBSS_ERR_NONE)
        else $error("call without code");
    a_fail_menus: assert property (
        $rose(panel_code_o == HBSS_ERR_BOOT_SURV) |-> menus_avail_o
        && sys_power_o) else $error("boot fail state");
    a_os_fail_on: assert property (
        panel_code_o == HBSS_ERR_OS_SURV |-> sys_power_o)
        else $error("os fail lost power");
endmodule
bind hbss_supervisor hbss_checker #(.MINUTE_CYCLES(MINUTE_CYCLES)) i_chk (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .heartbeat_i(heartbeat_i), .session_port2_i(session_port2_i),
    .con_data_i(con_data_i), .con_valid_i(con_valid_i),
    .port1_data_o(port1_data_o), .port1_valid_o(port1_valid_o),
    .port2_valid_o(port2_valid_o), .prompt_char_o(prompt_char_o),
    .sys_power_o(sys_power_o), .call_req_o(call_req_o),
    .menus_avail_o(menus_avail_o), .panel_code_o(panel_code_o));

/* sim/hbss_host_model.sv */
`timescale 1ns/1ps
module hbss_host_model
(
    input wire logic clk_sys_i,
    input wire logic beat_en_i,
    input wire logic [7:0] period_i,
    output logic heartbeat_o
);
    logic [7:0] cnt = 8'h00;
    initial heartbeat_o = 1'b0;
    // period must stay below the interval or false timeouts follow
    always @(posedge clk_sys_i)
    begin
        cnt <= (!beat_en_i || cnt == period_i) ? 8'h00 : cnt + 8'h01;
        heartbeat_o <= beat_en_i && cnt == period_i;
    end
endmodule

/* sim/hbss_supervisor_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    mismatches++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module hbss_supervisor_tb
    import hbss_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic drv = 1'b0;
    logic sess = 1'b0;
    logic p2h = 1'b0;
    logic [7:0] cdata = 8'h00;
    logic cval = 1'b0;
    logic beat_en = 1'b0;
    logic [15:0] prog = 16'h0e1a;
    logic [31:0] rdata;
    logic hb, p1v, p2v, pwr, call, menus;
    logic [7:0] p1d, p2d, prompt, panel;
    logic [15:0] rep;
    int mismatches = 0;
    int n_compared = 0;
    int n_falls = 0;
    always #50 clk = ~clk;
    always @(negedge pwr)
        if (!rst)
            n_falls++;
    hbss_supervisor #(.MINUTE_CYCLES(20)) i_hbss_supervisor (
        .clk_sys_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .heartbeat_i(hb),
        .driver_present_i(drv), .boot_progress_i(prog),
        .session_port2_i(sess), .ports_to_host_i(p2h), .con_data_i(cdata),
        .con_valid_i(cval), .port1_data_o(p1d), .port1_valid_o(p1v),
        .port2_data_o(p2d), .port2_valid_o(p2v), .prompt_char_o(prompt),
        .sys_power_o(pwr), .call_req_o(call), .menus_avail_o(menus),
        .panel_code_o(panel), .report_status_o(rep));
    hbss_host_model i_hbss_host_model (.clk_sys_i(clk),
        .beat_en_i(beat_en), .period_i(8'h0a), .heartbeat_o(hb));
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hffffffff);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK("reg", e, rdata & m)
    endtask
    task automatic sendb(input logic [7:0] b);
        @(posedge clk);
        cdata <= b;
        cval <= 1'b1;
        @(posedge clk);
        cval <= 1'b0;
        #1;
    endtask
    task automatic t_regs;
        rchk(HBSS_REG_CTRL, 32'h1);
        rchk(HBSS_REG_INTERVAL, 32'(HBSS_INTERVAL_RST));
        rchk(HBSS_REG_DELAY, 32'(HBSS_DELAY_RST));
        rchk(HBSS_REG_RETRY, 32'(HBSS_RETRY_RST));
        rchk(8'h1c, 32'h0);
        wreg(HBSS_REG_INTERVAL, 32'h1);
        rchk(HBSS_REG_STATUS, 32'h80000000, 32'h80000000);
        wreg(HBSS_REG_INTERVAL, 32'h100);
        rchk(HBSS_REG_INTERVAL, 32'(HBSS_INTERVAL_RST));
        wreg(HBSS_REG_INTERVAL, 32'h2);
        rchk(HBSS_REG_INTERVAL, 32'h2);
        wreg(HBSS_REG_INTERVAL, 32'hff);
        rchk(HBSS_REG_STATUS, 32'h0, 32'h80000000);
        wreg(HBSS_REG_DELAY, 32'h0);
        rchk(HBSS_REG_DELAY, 32'h0);
        wreg(HBSS_REG_CTRL, 32'h0);
        wreg(HBSS_REG_INTERVAL, 32'h9);
        rchk(HBSS_REG_INTERVAL, 32'hff);
        wreg(HBSS_REG_CTRL, 32'h1);
        wreg(HBSS_REG_INTERVAL, 32'h5);
        wreg(HBSS_REG_DELAY, 32'h1);
        rchk(HBSS_REG_STATUS, 32'h1, 32'h1f);
    endtask
    task automatic t_mirror;
        sendb(8'h5a);
        `CHK("p1", {2'b10, HBSS_CHAR_ONE}, {p1v, p2v, prompt})
        wreg(HBSS_REG_CTRL, 32'h5);
        sendb(8'ha5);
        `CHK("both", {2'b11, 8'ha5}, {p1v, p2v, p2d})
        @(posedge clk);
        p2h <= 1'b1;
        @(posedge clk);
        p2h <= 1'b0;
        sendb(8'h3c);
        `CHK("p1", 2'b10, {p1v, p2v})
        @(posedge clk);
        sess <= 1'b1;
        sendb(8'h77);
        `CHK("p2", {2'b01, 8'h77}, {p1v, p2v, p2d})
        `CHK("prompt", HBSS_CHAR_TWO, prompt)
    endtask
    task automatic t_boot;
        wreg(HBSS_REG_RETRY, 32'h2);
        wreg(HBSS_REG_CTRL, 32'h2);
        repeat (40) @(posedge clk);
        `CHK("pwr", 1'b0, pwr)
        wreg(HBSS_REG_CMD, 32'h1);
        #1 `CHK("pwr", 1'b1, pwr)
        rchk(HBSS_REG_STATUS, 32'h2, 32'h1f);
        for (int i = 0; i < 1500 && n_falls < 2; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        #1 `CHK("retry", {HBSS_ERR_BOOT_RETRY, 1'b1}, {panel, call})
        for (int i = 0; i < 1500 && panel !== HBSS_ERR_BOOT_SURV; i++)
            @(posedge clk);
        #1 `CHK("panel", HBSS_ERR_BOOT_SURV, panel)
        `CHK("on", 2'b11, {pwr, menus})
        `CHK("call", 1'b1, call)
        `CHK("report", prog, rep)
        `CHK("falls", 2, n_falls)
        rchk(HBSS_REG_STATUS, 32'h1, 32'h1f);
    endtask
    task automatic t_run;
        int f;
        wreg(HBSS_REG_CMD, 32'h4);
        #1 `CHK("call", 1'b0, call)
        wreg(HBSS_REG_CTRL, 32'h3);
        @(posedge clk);
        beat_en <= 1'b1;
        drv <= 1'b1;
        wreg(HBSS_REG_CMD, 32'h1);
        wreg(HBSS_REG_CMD, 32'h2);
        f = n_falls;
        repeat (400) @(posedge clk);
        rchk(HBSS_REG_STATUS, 32'h01000010, 32'h0100001f);
        `CHK("call", 1'b0, call)
        @(posedge clk);
        drv <= 1'b0;
        beat_en <= 1'b0;
        repeat (300) @(posedge clk);
        `CHK("call", 1'b0, call)
        drv <= 1'b1;
        for (int i = 0; i < 300 && call !== 1'b1; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        #1 `CHK("call", 1'b1, call)
        `CHK("falls", f, n_falls)
        `CHK("panel", HBSS_ERR_OS_SURV, panel)
        `CHK("pwr", 1'b1, pwr)
        rchk(HBSS_REG_STATUS, 32'h1, 32'h1f);
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_mirror();
        t_boot();
        t_run();
        print_verdict();
    end
    initial
    begin
        #(6000 * 100);
        mismatches++;
        print_verdict();
    end
endmodule
